// ### design/ppm_pkg.sv
// shared constants of the pin mode configuration block
// assumes the core register file decodes set and bank beside the address
package ppm_pkg;
    // register file addresses (set 1, bank 1)
    localparam logic [7:0] port0_low_addr = 8'he1;
    localparam logic [7:0] port5_high_addr = 8'he6;
    // values after reset
    localparam logic [7:0] port0_low_reset = 8'h00;
    localparam logic [7:0] port5_high_reset = 8'h00;
    // field layout: pin n of a group sits at bits 2n+1..2n
    localparam int field_width = 2;
    // pin mode codes
    localparam logic [1:0] mode_input = 2'h0;
    localparam logic [1:0] mode_pull_up = 2'h1;
    localparam logic [1:0] mode_alt = 2'h2;
    localparam logic [1:0] mode_push_pull = 2'h3;
    // kinds of alternative function on a pin
    localparam logic [1:0] alt_none = 2'h0;
    localparam logic [1:0] alt_drive = 2'h1;
    localparam logic [1:0] alt_sense = 2'h2;
endpackage

// ### design/ppm_pin_mode.sv
// one pin's mode decoder: turns a 2-bit mode into pad controls
// assumes mode comes from a register in the core clock domain
`timescale 1ns/1ps
module ppm_pin_mode #(
    parameter logic [1:0] alt_kind = 2'h1
) (
    // configuration
    input wire logic [1:0] mode,
    // core side
    input wire logic out_data,
    input wire logic alt_data,
    output logic in_data,
    output logic alt_in,
    // pad side
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    output logic pull_up
);
    // pad decode; an unavailable alternative acts as plain input
    always_comb begin
        pin_out = 1'b0;
        pin_oe = 1'b0;
        pull_up = 1'b0;
        alt_in = 1'b0;
        in_data = pin_in;
        case (mode)
            ppm_pkg::mode_input: begin
                pin_oe = 1'b0;
            end
            ppm_pkg::mode_pull_up: begin
                pull_up = 1'b1;
            end
            ppm_pkg::mode_alt: begin
                if (alt_kind == ppm_pkg::alt_drive) begin
                    pin_out = alt_data;
                    pin_oe = 1'b1;
                end else if (alt_kind == ppm_pkg::alt_sense) begin
                    alt_in = pin_in; // crystal path, digital input idle
                    in_data = 1'b0;
                end
            end
            ppm_pkg::mode_push_pull: begin
                pin_out = out_data;
                pin_oe = 1'b1;
            end
            default: begin
                pin_oe = 1'b0;
            end
        endcase
    end
endmodule

// ### design/ppm_port_pin_mode_config.sv
// pin mode registers for port 0 low pins and port 5 high pins
// assumes the core drives its register file port synchronous to core_clk
//
// Behaviour
// - low-byte register at E1H, set 1 bank 1
// - pins 3..0 use bits 7-6 down to 1-0
// - 00 input, 01 pull-up, 10 alternate, 11 output
// - all eight bits readable and writable
`timescale 1ns/1ps
module ppm_port_pin_mode_config (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // core register file port
    input wire logic [7:0] reg_addr,
    input wire logic reg_set1,
    input wire logic reg_bank1,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    // port 0 low pins, core side
    input wire logic [3:0] p0_out_data,
    output logic [3:0] p0_in_data,
    // lcd segment/common drive for port 0 pins 3..0
    input wire logic [3:0] lcd_line_level,
    // port 0 low pads (port_zero_pin_three .. port_zero_pin_zero)
    input wire logic [3:0] p0_pin_in,
    output logic [3:0] p0_pin_out,
    output logic [3:0] p0_pin_oe,
    output logic [3:0] p0_pull_up,
    // port 5 high pins, core side (bit 3 is port_five_pin_seven)
    input wire logic [3:0] p5_out_data,
    output logic [3:0] p5_in_data,
    output logic sub_crystal_input,
    // port 5 high pads
    input wire logic [3:0] p5_pin_in,
    output logic [3:0] p5_pin_out,
    output logic [3:0] p5_pin_oe,
    output logic [3:0] p5_pull_up
);
    logic [7:0] port0_low_pin_modes;
    logic [7:0] port5_high_pin_modes;
    logic [7:0] next_port0_low_pin_modes;
    logic [7:0] next_port5_high_pin_modes;
    logic [7:0] next_reg_rdata;
    logic in_bank;
    logic hit_p0;
    logic hit_p5;
    logic [3:0] p5_alt_in;

    // only set 1 bank 1 reaches these registers
    assign in_bank = reg_set1 && reg_bank1;
    assign hit_p0 = in_bank && (reg_addr == ppm_pkg::port0_low_addr);
    assign hit_p5 = in_bank && (reg_addr == ppm_pkg::port5_high_addr);
    assign reg_hit = hit_p0 || hit_p5;

    // register writes and read capture
    always_comb begin
        next_port0_low_pin_modes = port0_low_pin_modes;
        next_port5_high_pin_modes = port5_high_pin_modes;
        next_reg_rdata = reg_rdata;
        if (reg_wr && hit_p0) begin
            next_port0_low_pin_modes = reg_wdata;
        end
        if (reg_wr && hit_p5) begin
            next_port5_high_pin_modes = reg_wdata;
        end
        // read shows the old value when a write shares the cycle
        if (reg_rd) begin
            if (hit_p0) begin
                next_reg_rdata = port0_low_pin_modes;
            end else if (hit_p5) begin
                next_reg_rdata = port5_high_pin_modes;
            end else begin
                next_reg_rdata = 8'h00; // unmapped reads as zero
            end
        end
    end

    // all pins start as plain inputs so no pad fights the board
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            port0_low_pin_modes <= ppm_pkg::port0_low_reset;
            port5_high_pin_modes <= ppm_pkg::port5_high_reset;
            reg_rdata <= 8'h00;
        end else begin
            port0_low_pin_modes <= next_port0_low_pin_modes;
            port5_high_pin_modes <= next_port5_high_pin_modes;
            reg_rdata <= next_reg_rdata;
        end
    end

    // one decoder per pin; field n drives pin n
    for (genvar n = 0; n < 4; n++) begin : g_pin
        ppm_pin_mode #(.alt_kind(ppm_pkg::alt_drive)) u_p0 (
            .mode(port0_low_pin_modes[2*n +: 2]),
            .out_data(p0_out_data[n]),
            .alt_data(lcd_line_level[n]),
            .in_data(p0_in_data[n]),
            .alt_in(),
            .pin_in(p0_pin_in[n]),
            .pin_out(p0_pin_out[n]),
            .pin_oe(p0_pin_oe[n]),
            .pull_up(p0_pull_up[n])
        );
        // only the top pin has a usable alternate (crystal in)
        ppm_pin_mode #(
            .alt_kind(n == 3 ? ppm_pkg::alt_sense : ppm_pkg::alt_none)
        ) u_p5 (
            .mode(port5_high_pin_modes[2*n +: 2]),
            .out_data(p5_out_data[n]),
            .alt_data(1'b0),
            .in_data(p5_in_data[n]),
            .alt_in(p5_alt_in[n]),
            .pin_in(p5_pin_in[n]),
            .pin_out(p5_pin_out[n]),
            .pin_oe(p5_pin_oe[n]),
            .pull_up(p5_pull_up[n])
        );
    end
    assign sub_crystal_input = p5_alt_in[3];

    // checks: register access
    a_p0_write_lands: assert property (
        @(posedge core_clk) disable iff (!nrst)
        reg_wr && hit_p0 |=> port0_low_pin_modes == $past(reg_wdata))
        else $error("port 0 mode write not stored");
    a_p5_write_lands: assert property (
        @(posedge core_clk) disable iff (!nrst)
        reg_wr && hit_p5 |=> port5_high_pin_modes == $past(reg_wdata))
        else $error("port 5 mode write not stored");
    a_p0_read_back: assert property (
        @(posedge core_clk) disable iff (!nrst)
        reg_rd && hit_p0 |=> reg_rdata == $past(port0_low_pin_modes))
        else $error("port 0 mode read back wrong");
    a_p5_read_back: assert property (
        @(posedge core_clk) disable iff (!nrst)
        reg_rd && hit_p5 |=> reg_rdata == $past(port5_high_pin_modes))
        else $error("port 5 mode read back wrong");
    // the core may take read data late, so it must stand between reads
    a_rdata_holds: assert property (
        @(posedge core_clk) disable iff (!nrst)
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");

    // checks: address decode; other sets share these addresses
    a_wrong_bank_ignored: assert property (
        @(posedge core_clk) disable iff (!nrst)
        reg_wr && (reg_addr == ppm_pkg::port0_low_addr) && !in_bank
        |=> $stable(port0_low_pin_modes))
        else $error("write outside set 1 bank 1 changed port 0 modes");
    a_other_addr_ignored: assert property (
        @(posedge core_clk) disable iff (!nrst)
        reg_wr && !hit_p0 |=> $stable(port0_low_pin_modes))
        else $error("write elsewhere changed port 0 modes");
    a_unmapped_zero: assert property (
        @(posedge core_clk) disable iff (!nrst)
        reg_rd && !reg_hit |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");

    // checks: field to pin mapping
    a_pin3_field: assert property (
        @(posedge core_clk) disable iff (!nrst)
        port0_low_pin_modes[7:6] == ppm_pkg::mode_push_pull
        |-> p0_pin_oe[3] && p0_pin_out[3] == p0_out_data[3])
        else $error("pin 3 not driven from bits 7-6");
    a_pin0_field: assert property (
        @(posedge core_clk) disable iff (!nrst)
        port0_low_pin_modes[1:0] == ppm_pkg::mode_push_pull
        |-> p0_pin_oe[0] && p0_pin_out[0] == p0_out_data[0])
        else $error("pin 0 not driven from bits 1-0");

    // checks: mode decode on port 0
    a_mode_decode: assert property (
        @(posedge core_clk) disable iff (!nrst)
        port0_low_pin_modes[1:0] == ppm_pkg::mode_pull_up
        |-> p0_pull_up[0] && !p0_pin_oe[0])
        else $error("pull-up mode decoded wrong on pin 0");
    a_input_idle: assert property (
        @(posedge core_clk) disable iff (!nrst)
        port0_low_pin_modes[5:4] == ppm_pkg::mode_input
        |-> !p0_pin_oe[2] && !p0_pull_up[2] && p0_in_data[2] == p0_pin_in[2])
        else $error("plain input mode decoded wrong on pin 2");
    a_alt_lcd: assert property (
        @(posedge core_clk) disable iff (!nrst)
        port0_low_pin_modes[3:2] == ppm_pkg::mode_alt
        |-> p0_pin_oe[1] && p0_pin_out[1] == lcd_line_level[1])
        else $error("lcd alternate not routed to pin 1");

    // checks: mode decode on port 5; pins 6..4 have no alternate
    a_p5_push_pull: assert property (
        @(posedge core_clk) disable iff (!nrst)
        port5_high_pin_modes[5:4] == ppm_pkg::mode_push_pull
        |-> p5_pin_oe[2] && p5_pin_out[2] == p5_out_data[2])
        else $error("push-pull mode decoded wrong on port 5");
    a_p5_pull_up: assert property (
        @(posedge core_clk) disable iff (!nrst)
        port5_high_pin_modes[3:2] == ppm_pkg::mode_pull_up
        |-> p5_pull_up[1] && !p5_pin_oe[1])
        else $error("pull-up mode decoded wrong on port 5");
    a_p5_no_alt: assert property (
        @(posedge core_clk) disable iff (!nrst)
        port5_high_pin_modes[1:0] == ppm_pkg::mode_alt
        |-> !p5_pin_oe[0] && !p5_pull_up[0] && p5_in_data[0] == p5_pin_in[0])
        else $error("missing alternate not treated as input");
    a_crystal_route: assert property (
        @(posedge core_clk) disable iff (!nrst)
        port5_high_pin_modes[7:6] == ppm_pkg::mode_alt
        |-> sub_crystal_input == p5_pin_in[3] && !p5_in_data[3]
        && !p5_pin_oe[3])
        else $error("crystal input not routed from pin 7");
    a_crystal_idle: assert property (
        @(posedge core_clk) disable iff (!nrst)
        port5_high_pin_modes[7:6] != ppm_pkg::mode_alt
        |-> !sub_crystal_input)
        else $error("crystal input active outside its mode");

    // checks: reset leaves every pad undriven and without pull-up
    a_reset_clear: assert property (
        @(posedge core_clk)
        $rose(nrst) |-> port0_low_pin_modes == 8'h00
        && p0_pin_oe == 4'h0 && p0_pull_up == 4'h0)
        else $error("modes not cleared after reset");
    a_reset_p5_clear: assert property (
        @(posedge core_clk)
        $rose(nrst) |-> port5_high_pin_modes == 8'h00 && reg_rdata == 8'h00
        && p5_pin_oe == 4'h0 && p5_pull_up == 4'h0)
        else $error("port 5 modes or read data not cleared after reset");

    // scenarios worth seeing
    c_write_p0: cover property (@(posedge core_clk) reg_wr && hit_p0);
    c_read_p5: cover property (@(posedge core_clk) reg_rd && hit_p5);
    c_unmapped_read: cover property (@(posedge core_clk) reg_rd && !reg_hit);
    c_lcd_alt: cover property (@(posedge core_clk)
        port0_low_pin_modes[3:2] == ppm_pkg::mode_alt);
    c_crystal: cover property (@(posedge core_clk)
        port5_high_pin_modes[7:6] == ppm_pkg::mode_alt);
endmodule

// ### sim/ppm_pad_model.sv
// pad model for four pins: block driver, outside driver, pull-up
// assumes oe is high while the block drives the pad
`timescale 1ns/1ps
module ppm_pad_model (
    // pad controls from the block
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    input wire logic [3:0] pull_up,
    // outside world
    input wire logic [3:0] ext_level,
    input wire logic [3:0] ext_en,
    output logic [3:0] pad
);
    // a floating pad shows the inverse of the data, so no lucky match
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (pin_oe[i])
                pad[i] = pin_out[i];
            else if (ext_en[i])
                pad[i] = ext_level[i];
            else
                pad[i] = pull_up[i] | ~pin_out[i];
        end
    end
endmodule

// ### sim/test_port_pin_mode_config.sv
// bench for the pin mode registers, through the register file port
// assumes pads are modelled by ppm_pad_model
`timescale 1ns/1ps
module test_port_pin_mode_config;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_set1 = 1'b0;
    logic reg_bank1 = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] p0_out_data = 4'h5;
    logic [3:0] p5_out_data = 4'h6;
    logic [3:0] lcd_line_level = 4'ha;
    logic [3:0] ext_level = 4'h8;
    logic [3:0] ext_en = 4'h0;
    logic [7:0] reg_rdata;
    logic reg_hit;
    logic sub_crystal_input;
    logic [3:0] p0_in_data, p0_pin_in, p0_pin_out, p0_pin_oe, p0_pull_up;
    logic [3:0] p5_in_data, p5_pin_in, p5_pin_out, p5_pin_oe, p5_pull_up;
    logic [1:0] code;
    logic [7:0] want_val;
    int n_mismatch = 0;
    int num_checks = 0;
    localparam logic [7:0] lo = ppm_pkg::port0_low_addr;
    localparam logic [7:0] hi = ppm_pkg::port5_high_addr;

    ppm_port_pin_mode_config u_dut (.core_clk, .nrst, .reg_addr, .reg_set1,
        .reg_bank1, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_hit,
        .p0_out_data, .p0_in_data, .lcd_line_level, .p0_pin_in, .p0_pin_out,
        .p0_pin_oe, .p0_pull_up, .p5_out_data, .p5_in_data, .sub_crystal_input,
        .p5_pin_in, .p5_pin_out, .p5_pin_oe, .p5_pull_up);
    ppm_pad_model u_pad0 (.pin_out(p0_pin_out), .pin_oe(p0_pin_oe),
        .pull_up(p0_pull_up), .ext_level, .ext_en, .pad(p0_pin_in));
    ppm_pad_model u_pad5 (.pin_out(p5_pin_out), .pin_oe(p5_pin_oe),
        .pull_up(p5_pull_up), .ext_level, .ext_en, .pad(p5_pin_in));

    // 8 ns period
    always #4 core_clk = ~core_clk;

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        num_checks++;
        if (seen !== want) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h",
                $time, seen, want);
        end
    endtask

    // one strobe cycle held across the sampling edge, then an idle edge
    // so back-to-back calls never reassign a strobe in one time step
    task automatic access(input int w, input int a, input int d,
        input int sb);
        reg_wr = w[0];
        reg_rd = ~w[0];
        reg_addr = a[7:0];
        reg_wdata = d[7:0];
        {reg_set1, reg_bank1} = sb[1:0];
        @(posedge core_clk);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        @(posedge core_clk);
        #1;
    endtask

    task automatic conclude();
        if (n_mismatch == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // watchdog well beyond the roughly 60 cycles of the tests
    initial begin
        #40000;
        n_mismatch++;
        conclude();
    end

    initial begin
        repeat (8) @(posedge core_clk);
        #1;
        check({p0_pin_oe, p0_pull_up}, 8'h00);
        check(reg_rdata, 8'h00);
        nrst = 1'b1;
        access(0, lo, 0, 3);
        check(reg_rdata, ppm_pkg::port0_low_reset);
        access(0, hi, 0, 3);
        check(reg_rdata, ppm_pkg::port5_high_reset);
        // every code on all four pins at once; a floating pad reads high
        for (int m = 0; m < 4; m++) begin
            code = m[1:0];
            access(1, lo, {4{code}}, 3);
            access(0, lo, 0, 3);
            check(reg_rdata, {4{code}});
            want_val = {{4{code[1]}}, {4{code == ppm_pkg::mode_pull_up}}};
            check({p0_pin_oe, p0_pull_up}, want_val);
            want_val = {4'h0, code[0] ? p0_out_data : lcd_line_level};
            want_val = code[1] ? want_val : 8'h00;
            check({4'h0, p0_pin_out & {4{code[1]}}}, want_val);
            want_val = code[1] ? want_val : 8'h0f;
            check({4'h0, p0_in_data}, want_val);
        end
        // one field at a time lands on its own pin
        for (int p = 0; p < 4; p++) begin
            access(1, lo, 8'h03 << (2 * p), 3);
            check({4'h0, p0_pin_oe}, 8'h01 << p);
        end
        // wrong set, wrong bank, wrong address are ignored
        access(1, lo, 8'h55, 1);
        check({7'h00, reg_hit}, 8'h00);
        access(1, lo, 8'h55, 2);
        access(1, 8'he2, 8'h55, 3);
        access(0, lo, 0, 3);
        check(reg_rdata, 8'hc0);
        check({7'h00, reg_hit}, 8'h01);
        access(0, 8'he2, 0, 3);
        check(reg_rdata, 8'h00);
        check({7'h00, reg_hit}, 8'h00);
        // crystal pin routes the pad away from the digital input
        ext_level = 4'hd;
        ext_en = 4'hf;
        access(1, hi, 8'h80, 3);
        check({3'h0, sub_crystal_input, p5_in_data}, 8'h15);
        // pins 6..4 have no alternate and stay plain inputs
        access(1, hi, 8'h2a, 3);
        check({3'h0, sub_crystal_input, p5_in_data}, 8'h0d);
        check({p5_pull_up, p5_pin_oe}, 8'h00);
        access(1, hi, 8'hff, 3);
        check({p5_pin_oe, p5_pin_out}, {4'hf, p5_out_data});
        access(1, hi, 8'h55, 3);
        check({p5_pull_up, p5_pin_oe}, 8'hf0);
        access(0, hi, 0, 3);
        check(reg_rdata, 8'h55);
        // second reset in mid-run clears both registers
        nrst = 1'b0;
        @(posedge core_clk);
        #1;
        nrst = 1'b1;
        check({p5_pin_oe, p0_pin_oe}, 8'h00);
        check({p5_pull_up, p0_pull_up}, 8'h00);
        access(0, hi, 0, 3);
        check(reg_rdata, 8'h00);
        access(0, lo, 0, 3);
        check(reg_rdata, 8'h00);
        conclude();
    end
endmodule
